//--- fdisc_device.sv
// frequency discriminator, frequency error detector and its output FIFO
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps

module fdisc_fifo
	import fdisc_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wp;
	logic [PW-1:0]    rp;
	logic [PW:0]      count;
	logic             push;
	logic             pop;
	logic [PW-1:0]    next_rp;
	logic [PW:0]      next_count;

	assign push       = in_valid & in_ready;
	assign pop        = out_valid & out_ready;
	assign next_rp    = pop ? PW'(rp + 1'b1) : rp;
	assign next_count = count + (PW+1)'(push) - (PW+1)'(pop);

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			wp    <= '0;
			rp    <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wp <= PW'(wp + 1'b1);
			end
			rp    <= next_rp;
			count <= next_count;
		end
	end

	// flags and head word registered so consumers see flop outputs
	always_ff @(posedge clk) begin
		if (!nrst) begin
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
			out_data  <= '0;
		end else begin
			in_ready  <= (next_count != (PW+1)'(DEPTH));
			out_valid <= (next_count != '0);
			if (push && (wp == next_rp)) begin
				out_data <= in_data;
			end else begin
				out_data <= mem[next_rp];
			end
		end
	end
endmodule

module fdisc_device
	import fdisc_pkg::*;
(
	input  wire logic SYS_CLK,
	input  wire logic NRST,
	fdisc_if.dev      LINK,
	input  wire phase_t     PHASE,
	input  wire logic       PHASE_VALID,
	output logic            PHASE_READY,
	input  wire loop_word_t LEAD,
	input  wire loop_word_t LAG
);
	ctrl_t      freq_det_ctrl;
	ctrl_t      freq_err_ctrl;
	ctrl_t      carrier_lf1_ctrl;
	phase_t     hist [`HIST_DEPTH];
	phase_t     delayed;
	phase_t     diff;
	phase_t     with_offset;
	phase_t     ferr;
	logic [2:0] delay_k;
	logic [2:0] shift;
	logic [4:0] offset;
	logic [4:0] top_sum;
	logic       take;
	logic       fifo_in_ready;
	logic       fifo_out_valid;
	phase_t     fifo_out_data;

	// control words keep only the low byte
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			freq_det_ctrl    <= `CTRL_RESET;
			freq_err_ctrl    <= `CTRL_RESET;
			carrier_lf1_ctrl <= `CTRL_RESET;
		end else if (LINK.cfg_wr) begin
			case (LINK.cfg_addr)
				`ADDR_FREQ_DET: begin
					freq_det_ctrl <= LINK.cfg_wdata[`CTRL_BITS-1:0];
				end
				`ADDR_FREQ_ERR_DET: begin
					freq_err_ctrl <= LINK.cfg_wdata[`CTRL_BITS-1:0];
				end
				`ADDR_CARRIER_LF1: begin
					carrier_lf1_ctrl <= LINK.cfg_wdata[`CTRL_BITS-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	assign delay_k = freq_det_ctrl[`DELAY_MSB:`DELAY_LSB];
	assign offset  = freq_err_ctrl[`OFFSET_MSB:`OFFSET_LSB];
	assign shift   = freq_err_ctrl[`SHIFT_MSB:`SHIFT_LSB];
	assign take    = PHASE_VALID & fifo_in_ready;

	// history of earlier samples, newest in entry 0
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			hist[0] <= '0;
		end else if (take) begin
			hist[0] <= PHASE;
		end
	end

	genvar gi;
	generate
		for (gi = 1; gi < `HIST_DEPTH; gi++) begin : g_hist
			always_ff @(posedge SYS_CLK) begin
				if (!NRST) begin
					hist[gi] <= '0;
				end else if (take) begin
					hist[gi] <= hist[gi-1];
				end
			end
		end
	endgenerate

	// delay of 2**K samples; settings above four hold at sixteen
	always_comb begin
		case (delay_k)
			3'h0: delayed = hist[0];
			3'h1: delayed = hist[1];
			3'h2: delayed = hist[3];
			3'h3: delayed = hist[7];
			default: delayed = hist[15];
		endcase
	end

	assign diff = PHASE - delayed;

	// fractional offset, -1.0 to +0.9375 in sixteenths, wraps
	assign top_sum     = diff[`PHASE_W-1:`PHASE_W-5] + offset;
	assign with_offset = {top_sum, diff[`PHASE_W-6:0]};

	always_comb begin
		case (shift)
			3'h0: ferr = with_offset;
			3'h1: ferr = {with_offset[`PHASE_W-2:0], 1'h0};
			3'h2: ferr = {with_offset[`PHASE_W-3:0], 2'h0};
			3'h3: ferr = {with_offset[`PHASE_W-4:0], 3'h0};
			default: ferr = {with_offset[`PHASE_W-5:0], 4'h0};
		endcase
	end

	fdisc_fifo #(
		.WIDTH(`PHASE_W),
		.DEPTH(`FIFO_DEPTH)
	) u_fifo (
		.clk      (SYS_CLK),
		.nrst     (NRST),
		.in_data  (ferr),
		.in_valid (PHASE_VALID),
		.in_ready (fifo_in_ready),
		.out_data (fifo_out_data),
		.out_valid(fifo_out_valid),
		.out_ready(LINK.ferr_ready)
	);

	assign LINK.ferr_valid = fifo_out_valid;
	assign LINK.ferr_data  = fifo_out_data;

	// room flag of the fifo; a sample offered while low is lost
	assign PHASE_READY = fifo_in_ready;

	// serial output routing
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			LINK.serial_word <= '0;
		end else if (carrier_lf1_ctrl[`ROUTE_BIT]) begin
			LINK.serial_word <= LEAD + LAG;
		end else begin
			LINK.serial_word <= LAG;
		end
	end
endmodule

//--- fdisc_consts.svh
// constants for the frequency discriminator and error detector
// Summary of operation
// - frequency is current minus delayed phase
// - delay is two to the K, bits 2..0
// - delays of 1 to 16 samples set gain
// - offset is bits 7..3, fractional two's complement
// - offset spans +0.9375 to -1.0, 1/16 steps
// - offset added modulo to top five bits
// - error shifted left 0 to 4 places
// - controller never programs shift above four
// - controller zeroes offset for PSK aided acquisition
// - controller zeroes shift for PSK aided acquisition
// - controller writes zero to reserved bits
// - route bit clear sends lag accumulator out
// - route bit set sends lead plus lag
`ifndef FDISC_CONSTS_SVH
`define FDISC_CONSTS_SVH

`define PHASE_W            8
`define LOOP_W             32
`define ADDR_W             4
`define FIFO_DEPTH         16
`define HIST_DEPTH         16
`define CTRL_BITS          8
`define ADDR_FREQ_DET      4'h4
`define ADDR_FREQ_ERR_DET  4'h5
`define ADDR_CARRIER_LF1   4'h6
`define ADDR_HOST_MODE     4'h1
`define ADDR_HOST_STATUS   4'h0
`define DELAY_LSB          0
`define DELAY_MSB          2
`define OFFSET_LSB         3
`define OFFSET_MSB         7
`define SHIFT_LSB          0
`define SHIFT_MSB          2
`define SHIFT_MAX          3'h4
`define ROUTE_BIT          6
`define DELAY_RSVD_MASK    8'h07
`define LF1_RSVD_MASK      8'h7F
`define MODE_PSK_FAA_BIT   0
`define CTRL_RESET         8'h00

`endif

//--- fdisc_pkg.sv
// types shared by both ends of the frequency detector link
`include "fdisc_consts.svh"
package fdisc_pkg;
	typedef logic [`PHASE_W-1:0]    phase_t;
	typedef logic [`LOOP_W-1:0]     loop_word_t;
	typedef logic [`CTRL_BITS-1:0]  ctrl_t;
	typedef logic [`ADDR_W-1:0]     addr_t;
endpackage

//--- fdisc_if.sv
// link between the frequency detector and its controlling party
`timescale 1ns/100ps
interface fdisc_if;
	import fdisc_pkg::*;
	logic       cfg_wr;
	addr_t      cfg_addr;
	loop_word_t cfg_wdata;
	logic       ferr_valid;
	logic       ferr_ready;
	phase_t     ferr_data;
	loop_word_t serial_word;
	modport dev (
		input  cfg_wr,
		input  cfg_addr,
		input  cfg_wdata,
		output ferr_valid,
		input  ferr_ready,
		output ferr_data,
		output serial_word
	);
	modport ctl (
		output cfg_wr,
		output cfg_addr,
		output cfg_wdata,
		input  ferr_valid,
		output ferr_ready,
		input  ferr_data,
		input  serial_word
	);
endinterface

//--- fdisc_host.sv
// controlling party: software port, control word sanitising, error sink
`timescale 1ns/100ps
module fdisc_host
	import fdisc_pkg::*;
(
	input  wire logic       SYS_CLK,
	input  wire logic       NRST,
	fdisc_if.ctl            LINK,
	input  wire addr_t      ADDR,
	input  wire loop_word_t WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output loop_word_t      RDATA,
	output phase_t          FERR_DATA,
	output logic            FERR_VALID,
	input  wire logic       FERR_READY,
	output loop_word_t      SERIAL_OUT
);
	ctrl_t      shadow_det;
	ctrl_t      shadow_err;
	ctrl_t      shadow_lf1;
	logic       psk_faa;
	logic [7:0] err_count;
	ctrl_t      clean;
	logic       take;
	logic       next_valid;

	// reserved bits zero, shift clamped, PSK aided mode zeroes offset/shift
	always_comb begin
		clean = WDATA[`CTRL_BITS-1:0];
		case (ADDR)
			`ADDR_FREQ_DET: clean = clean & `DELAY_RSVD_MASK;
			`ADDR_FREQ_ERR_DET: begin
				if (clean[`SHIFT_MSB:`SHIFT_LSB] > `SHIFT_MAX) begin
					clean[`SHIFT_MSB:`SHIFT_LSB] = `SHIFT_MAX;
				end
				if (psk_faa) begin
					clean = `CTRL_RESET;
				end
			end
			`ADDR_CARRIER_LF1: clean = clean & `LF1_RSVD_MASK;
			default: clean = `CTRL_RESET;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			LINK.cfg_wr    <= 1'b0;
			LINK.cfg_addr  <= '0;
			LINK.cfg_wdata <= '0;
		end else begin
			LINK.cfg_wr    <= WR && (ADDR == `ADDR_FREQ_DET || ADDR == `ADDR_FREQ_ERR_DET
				|| ADDR == `ADDR_CARRIER_LF1);
			LINK.cfg_addr  <= ADDR;
			LINK.cfg_wdata <= {{(`LOOP_W-`CTRL_BITS){1'b0}}, clean};
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			shadow_det <= `CTRL_RESET;
			shadow_err <= `CTRL_RESET;
			shadow_lf1 <= `CTRL_RESET;
			psk_faa    <= 1'b0;
		end else if (WR) begin
			case (ADDR)
				`ADDR_FREQ_DET: shadow_det <= clean;
				`ADDR_FREQ_ERR_DET: shadow_err <= clean;
				`ADDR_CARRIER_LF1: shadow_lf1 <= clean;
				`ADDR_HOST_MODE: psk_faa <= WDATA[`MODE_PSK_FAA_BIT];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			RDATA <= '0;
		end else if (RD) begin
			case (ADDR)
				`ADDR_HOST_STATUS: RDATA <= {24'h000000, err_count};
				`ADDR_HOST_MODE: RDATA <= {31'h00000000, psk_faa};
				`ADDR_FREQ_DET: RDATA <= {24'h000000, shadow_det};
				`ADDR_FREQ_ERR_DET: RDATA <= {24'h000000, shadow_err};
				`ADDR_CARRIER_LF1: RDATA <= {24'h000000, shadow_lf1};
				default: RDATA <= '0;
			endcase
		end else begin
			RDATA <= '0;
		end
	end

	// one-word holding stage for frequency errors
	assign take       = LINK.ferr_valid & LINK.ferr_ready;
	assign next_valid = (FERR_VALID & ~FERR_READY) | take;

	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			FERR_VALID      <= 1'b0;
			FERR_DATA       <= '0;
			LINK.ferr_ready <= 1'b0;
			err_count       <= '0;
		end else begin
			FERR_VALID      <= next_valid;
			LINK.ferr_ready <= ~next_valid;
			if (take) begin
				FERR_DATA <= LINK.ferr_data;
				err_count <= err_count + 8'h01;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			SERIAL_OUT <= '0;
		end else begin
			SERIAL_OUT <= LINK.serial_word;
		end
	end
endmodule

//--- fdisc_link_sva.sv
// assertions on the link between the two frequency detector ends
`timescale 1ns/100ps
module fdisc_link_sva
	import fdisc_pkg::*;
(
	input  wire logic       SYS_CLK,
	input  wire logic       NRST,
	input  wire logic       cfg_wr,
	input  wire addr_t      cfg_addr,
	input  wire loop_word_t cfg_wdata,
	input  wire logic       ferr_valid,
	input  wire logic       ferr_ready,
	input  wire phase_t     ferr_data,
	input  wire loop_word_t serial_word
);
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!NRST);

	a_head_holds: assert property (ferr_valid && !ferr_ready |=> ferr_valid)
		else $error("fifo head dropped before accept");
	a_data_stable: assert property (ferr_valid && !ferr_ready |=> $stable(ferr_data))
		else $error("fifo head changed before accept");
	a_ready_drops: assert property (ferr_valid && ferr_ready |=> !ferr_ready)
		else $error("sink ready stayed high after taking a word");
	a_reset_ready: assert property ($rose(NRST) |-> !ferr_valid ##1 ferr_ready)
		else $error("sink not ready one edge after reset");
	a_delay_clean: assert property (cfg_wr && cfg_addr == 4'h4 |-> cfg_wdata[31:3] == 29'h0)
		else $error("delay word sent with reserved bits set");
	a_route_clean: assert property (cfg_wr && cfg_addr == 4'h6 |-> cfg_wdata[31:7] == 25'h0)
		else $error("route word sent with reserved bits set");
	a_shift_legal: assert property (cfg_wr && cfg_addr == 4'h5 |-> cfg_wdata[2:0] <= 3'h4)
		else $error("shift above four sent");
	a_addr_legal: assert property (cfg_wr |-> cfg_addr inside {4'h4, 4'h5, 4'h6})
		else $error("control write to unknown address");
endmodule

//--- test_frequency_discriminator_error_detector.sv
// self-checking bench for the frequency detector pair
`timescale 1ns/100ps
module test_frequency_discriminator_error_detector
	import fdisc_pkg::*;
;
	typedef struct {logic [2:0] k; logic [4:0] off; logic [2:0] sh; phase_t stp;} row_t;
	row_t       rows [6] = '{'{3'h0, 5'h00, 3'h0, 8'h03}, '{3'h1, 5'h1F, 3'h1, 8'h07},
		'{3'h2, 5'h10, 3'h2, 8'h0B}, '{3'h3, 5'h0F, 3'h3, 8'h05}, '{3'h4, 5'h08, 3'h4, 8'h09},
		'{3'h6, 5'h00, 3'h0, 8'h0D}};
	addr_t      sa [4] = '{4'h4, 4'h6, 4'h5, 4'h3};
	loop_word_t sw [4] = '{32'hFF, 32'hFF, 32'h07, 32'hAA};
	loop_word_t se [4] = '{32'h07, 32'h7F, 32'h04, 32'h00};
	logic       sys_clk = 1'b0;
	logic       nrst = 1'b0;
	addr_t      addr = '0;
	loop_word_t wdata = '0;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       ferr_ready = 1'b1;
	phase_t     phase = '0;
	logic       phase_valid = 1'b0;
	loop_word_t lead = '0;
	loop_word_t lag = '0;
	loop_word_t rdata;
	loop_word_t serial_out;
	loop_word_t v;
	phase_t     ferr_data;
	logic       ferr_valid;
	logic       phase_ready;
	phase_t     hq [16] = '{default: '0};
	phase_t     expq [$];
	phase_t     p = '0;
	logic [2:0] k = '0;
	logic [4:0] off = '0;
	logic [2:0] sh = '0;
	int         err_count = 0;
	int         samples_checked = 0;
	int         cycles = 0;
	int         rcv = 0;

	fdisc_if link();
	fdisc_device i_fdisc_device (.SYS_CLK(sys_clk), .NRST(nrst), .LINK(link), .PHASE(phase),
		.PHASE_VALID(phase_valid), .PHASE_READY(phase_ready), .LEAD(lead), .LAG(lag));
	fdisc_host i_fdisc_host (.SYS_CLK(sys_clk), .NRST(nrst), .LINK(link), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .FERR_DATA(ferr_data), .FERR_VALID(ferr_valid),
		.FERR_READY(ferr_ready), .SERIAL_OUT(serial_out));
	fdisc_link_sva i_chk (.SYS_CLK(sys_clk), .NRST(nrst), .cfg_wr(link.cfg_wr), .cfg_addr(link.cfg_addr),
		.cfg_wdata(link.cfg_wdata), .ferr_valid(link.ferr_valid), .ferr_ready(link.ferr_ready),
		.ferr_data(link.ferr_data), .serial_word(link.serial_word));

	always #4 sys_clk = ~sys_clk;

	// reference error for one taken sample, history advanced
	function automatic phase_t model(phase_t x);
		phase_t d;
		d = x - hq[(k > 3'h4) ? 15 : (1 << k) - 1];
		d[7:3] = d[7:3] + off;
		for (int i = 15; i > 0; i--) hq[i] = hq[i - 1];
		hq[0] = x;
		return d << sh;
	endfunction

	task report_and_stop;
		$display("compares %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task chk(input loop_word_t s, input loop_word_t e);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task wr_reg(input addr_t a, input loop_word_t d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask

	task rd_reg(input addr_t a);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	task send(input phase_t x);
		@(posedge sys_clk);
		phase <= x;
		phase_valid <= 1'b1;
		expq.push_back(model(x));
		@(posedge sys_clk);
		phase_valid <= 1'b0;
	endtask

	task settle;
		repeat (40) @(posedge sys_clk);
		chk(expq.size(), 0);
	endtask

	task cfg(input logic [2:0] nk, input logic [4:0] no, input logic [2:0] ns);
		k = nk;
		off = no;
		sh = ns;
		wr_reg(4'h4, {29'h0, nk});
		wr_reg(4'h5, {24'h0, no, ns});
		repeat (3) @(posedge sys_clk);
	endtask

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			report_and_stop();
		end
	end

	always @(posedge sys_clk) begin
		if (nrst && ferr_valid === 1'b1 && ferr_ready) begin
			rcv++;
			chk(ferr_data, expq.size() ? expq.pop_front() : 8'hXX);
		end
	end

	initial begin
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		rd_reg(4'h5);
		chk(v, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr_reg(sa[i], sw[i]);
			rd_reg(sa[i]);
			chk(v, se[i]);
		end
		// psk aided acquisition mode forces offset and shift to zero
		wr_reg(4'h1, 32'h01);
		rd_reg(4'h1);
		chk(v, 32'h1);
		wr_reg(4'h5, 32'hFF);
		rd_reg(4'h5);
		chk(v, 32'h0);
		wr_reg(4'h1, 32'h00);
		foreach (rows[r]) begin
			cfg(rows[r].k, rows[r].off, rows[r].sh);
			for (int i = 0; i < 24; i++) begin
				p = p + rows[r].stp;
				send(p);
			end
			settle();
		end
		lead <= 32'hF000_0001;
		lag <= 32'h2000_0003;
		// route bit is still set from the mask test, so clear it first
		wr_reg(4'h6, 32'h00);
		repeat (4) @(posedge sys_clk);
		chk(serial_out, 32'h2000_0003);
		wr_reg(4'h6, 32'h40);
		repeat (4) @(posedge sys_clk);
		chk(serial_out, 32'h1000_0004);
		// fill the fifo with the sink stalled; later samples are dropped
		cfg(3'h1, 5'h03, 3'h1);
		ferr_ready <= 1'b0;
		for (int i = 0; i < 20; i++) begin
			@(posedge sys_clk);
			phase <= p;
			phase_valid <= 1'b1;
			if (i < 17) expq.push_back(model(p));
			p = p + 8'h05;
		end
		@(posedge sys_clk);
		chk(phase_ready, 1'b0);
		phase_valid <= 1'b0;
		ferr_ready <= 1'b1;
		settle();
		chk(phase_ready, 1'b1);
		rd_reg(4'h0);
		chk(v, {24'h0, rcv[7:0]});
		nrst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		hq = '{default: '0};
		k = '0;
		off = '0;
		sh = '0;
		rd_reg(4'h4);
		chk(v, 32'h0);
		send(8'h21);
		settle();
		report_and_stop();
	end
endmodule
